// [pmu_buck_ch.sv]
`timescale 1ns/100ps
`include "pmu_regs.svh"

module pmu_buck_ch
    import pmu_pkg::*;
#(
    parameter logic [7:0] CTL_ADDR = `PMU_A_B1_CTL,
    parameter logic [7:0] VP_ADDR  = `PMU_A_B2_VP,
    parameter logic [7:0] VS_ADDR  = `PMU_A_B2_VS,
    parameter bit         HAS_VSET = 1'b1
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // register access
    input  wire pmu_req_t                req_i,
    // regulator side
    input  wire logic                    voltage_select_pin_i,
    input  wire logic                    pg_i,
    input  wire logic                    fault_i,
    // state out
    output pmu_buck_cfg_t                cfg_o,
    output logic [`PMU_VCODE_W-1:0]      code_o,
    output logic [7:0]                   ctl_rd_o,
    output logic [7:0]                   vp_rd_o,
    output logic [7:0]                   vs_rd_o,
    output logic                         fault_irq_o
);

    pmu_buck_cfg_t                cfg_reg,  cfg_next;
    logic [`PMU_VCODE_W-1:0]      vp_reg,   vp_next;
    logic [`PMU_VCODE_W-1:0]      vs_reg,   vs_next;
    logic [`PMU_VCODE_W-1:0]      code_reg, code_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        cfg_next  = cfg_reg;
        vp_next   = vp_reg;
        vs_next   = vs_reg;
        if (pmu_wr_hit(req_i, CTL_ADDR)) begin
            cfg_next.on               = req_i.wdata[`PMU_B_ON];
            cfg_next.phase            = req_i.wdata[`PMU_B_PHASE];
            cfg_next.fault_irq_enable = req_i.wdata[`PMU_B_FLTEN];
        end
        if (HAS_VSET && pmu_wr_hit(req_i, VP_ADDR)) begin
            vp_next = req_i.wdata[`PMU_VCODE_W-1:0];
        end
        if (HAS_VSET && pmu_wr_hit(req_i, VS_ADDR)) begin
            vs_next = req_i.wdata[`PMU_VCODE_W-1:0];
        end
        // pin is sampled each cycle so a select flip takes effect on the next edge
        code_next = voltage_select_pin_i ? vs_reg : vp_reg;
        if (!HAS_VSET) begin
            code_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg  <= '0;
            vp_reg   <= '0;
            vs_reg   <= '0;
            code_reg <= '0;
        end else begin
            cfg_reg  <= cfg_next;
            vp_reg   <= vp_next;
            vs_reg   <= vs_next;
            code_reg <= code_next;
        end
    end

    // ----------------------------------------
    // readback, reserved bits fixed at zero
    // ----------------------------------------
    assign cfg_o       = cfg_reg;
    assign code_o      = code_reg;
    assign ctl_rd_o    = {cfg_reg.on, 4'h0, cfg_reg.phase,
                          cfg_reg.fault_irq_enable, pg_i};
    assign vp_rd_o     = {2'h0, vp_reg};
    assign vs_rd_o     = {2'h0, vs_reg};
    assign fault_irq_o = fault_i & cfg_reg.fault_irq_enable;

endmodule : pmu_buck_ch

// [pmu_host_model.sv]
`timescale 1ns/100ps

module pmu_host_model
    import pmu_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // register access
    output pmu_req_t        req_o,
    input  wire logic [7:0] rdata_i
);

    initial req_o = '0;

    // one strobe cycle, then release so consecutive calls never share an edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        req_o <= '0;
    endtask : wr

    // read data is registered at the taking edge and held, so sample it half a cycle later
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '0;
        @(negedge clk_i);
        data = rdata_i;
    endtask : rd

endmodule : pmu_host_model

// [pmu_pkg.sv]
package pmu_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmu_req_t;

    typedef struct packed {
        logic on;
        logic phase;
        logic fault_irq_enable;
    } pmu_buck_cfg_t;

    function automatic logic pmu_wr_hit(input pmu_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : pmu_wr_hit

    function automatic logic pmu_rd_hit(input pmu_req_t r, input logic [7:0] a);
        return r.rd && (r.addr == a);
    endfunction : pmu_rd_hit

endpackage : pmu_pkg

// [pmu_regbank.sv]
`timescale 1ns/100ps
`include "pmu_regs.svh"

module pmu_regbank
    import pmu_pkg::*;
#(
    parameter int NBUCK = `PMU_NBUCK
) (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // register access port
    input  wire pmu_req_t                      req_i,
    output logic [7:0]                         rdata_o,
    // analog status
    input  wire logic                          battery_below_i,
    input  wire logic                          thermal_alert_i,
    input  wire logic [NBUCK-1:0]              buck_power_good_i,
    input  wire logic [NBUCK-1:0]              buck_fault_i,
    input  wire logic                          voltage_select_pin_i,
    // regulator controls
    output logic [`PMU_THR_W-1:0]              battery_detect_threshold_o,
    output logic [NBUCK-1:0]                   buck_enable_o,
    output logic [NBUCK-1:0]                   buck_phase_o,
    output logic [NBUCK-2:0][`PMU_VCODE_W-1:0] buck_vcode_o,
    // interrupt
    output logic                               irq_o
);

    localparam logic [7:0] CTL_A [4] = '{`PMU_A_B1_CTL, `PMU_A_B2_CTL,
                                         `PMU_A_B3_CTL, `PMU_A_B4_CTL};
    localparam logic [7:0] VP_A  [4] = '{`PMU_A_B2_VP, `PMU_A_B2_VP,
                                         `PMU_A_B3_VP, `PMU_A_B4_VP};
    localparam logic [7:0] VS_A  [4] = '{`PMU_A_B2_VS, `PMU_A_B2_VS,
                                         `PMU_A_B3_VS, `PMU_A_B4_VS};

    // ----------------------------------------
    // system register state
    // ----------------------------------------
    logic                     batt_unmask_reg,  batt_unmask_next;
    logic                     batt_rsv_reg,     batt_rsv_next;
    logic [`PMU_THR_W-1:0]    thr_reg,          thr_next;
    logic                     batt_flag_reg,    batt_flag_next;
    logic                     batt_prev_reg,    batt_prev_next;
    logic                     therm_unmask_reg, therm_unmask_next;
    logic [`PMU_TRSV_W-1:0]   therm_rsv_reg,    therm_rsv_next;
    logic                     therm_flag_reg,   therm_flag_next;
    logic                     therm_prev_reg,   therm_prev_next;
    logic [7:0]               rdata_reg,        rdata_next;
    logic                     irq_reg,          irq_next;

    // ----------------------------------------
    // buck channels
    // ----------------------------------------
    pmu_buck_cfg_t                 cfg   [NBUCK];
    logic [`PMU_VCODE_W-1:0]       code  [NBUCK];
    logic [7:0]                    ctl_rd [NBUCK];
    logic [7:0]                    vp_rd  [NBUCK];
    logic [7:0]                    vs_rd  [NBUCK];
    logic [NBUCK-1:0]              fault_irq;

    for (genvar k = 0; k < NBUCK; k++) begin : g_buck
        pmu_buck_ch #(
            .CTL_ADDR (CTL_A[k]),
            .VP_ADDR  (VP_A[k]),
            .VS_ADDR  (VS_A[k]),
            .HAS_VSET (k > 0)
        ) pmu_buck_ch_i (
            .clk_i                (clk_i),
            .rst_i                (rst_i),
            .req_i                (req_i),
            .voltage_select_pin_i (voltage_select_pin_i),
            .pg_i                 (buck_power_good_i[k]),
            .fault_i              (buck_fault_i[k]),
            .cfg_o                (cfg[k]),
            .code_o               (code[k]),
            .ctl_rd_o             (ctl_rd[k]),
            .vp_rd_o              (vp_rd[k]),
            .vs_rd_o              (vs_rd[k]),
            .fault_irq_o          (fault_irq[k])
        );
        assign buck_enable_o[k] = cfg[k].on;
        assign buck_phase_o[k]  = cfg[k].phase;
        if (k > 0) begin : g_code
            assign buck_vcode_o[k-1] = code[k];
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic batt_set;
        logic therm_set;
        batt_set  = battery_below_i & ~batt_prev_reg;
        therm_set = thermal_alert_i & ~therm_prev_reg;

        batt_unmask_next  = batt_unmask_reg;
        batt_rsv_next     = batt_rsv_reg;
        thr_next          = thr_reg;
        therm_unmask_next = therm_unmask_reg;
        therm_rsv_next    = therm_rsv_reg;
        batt_prev_next    = battery_below_i;
        therm_prev_next   = thermal_alert_i;

        // status bits are not writable; control and reserved fields are taken
        if (pmu_wr_hit(req_i, `PMU_A_BATT)) begin
            batt_unmask_next = req_i.wdata[`PMU_B_UNMASK];
            batt_rsv_next    = req_i.wdata[`PMU_B_BRSV];
            thr_next         = req_i.wdata[`PMU_THR_W-1:0];
        end
        if (pmu_wr_hit(req_i, `PMU_A_THERM)) begin
            therm_unmask_next = req_i.wdata[`PMU_B_UNMASK];
            therm_rsv_next    = req_i.wdata[`PMU_TRSV_W-1:0];
        end

        // flags are read-to-clear; a new edge in the same cycle wins
        batt_flag_next  = batt_set |
                          (batt_flag_reg & ~pmu_rd_hit(req_i, `PMU_A_BATT));
        therm_flag_next = therm_set |
                          (therm_flag_reg & ~pmu_rd_hit(req_i, `PMU_A_THERM));

        // unmapped addresses read as zero; data holds between reads
        rdata_next = rdata_reg;
        if (req_i.rd) begin
            rdata_next = `PMU_RST_BYTE;
            case (req_i.addr)
                `PMU_A_BATT: begin
                    rdata_next = {batt_unmask_reg, batt_flag_reg,
                                  battery_below_i, batt_rsv_reg, thr_reg};
                end
                `PMU_A_THERM: begin
                    rdata_next = {therm_unmask_reg, therm_flag_reg, therm_rsv_reg};
                end
                default: begin
                    for (int k = 0; k < NBUCK; k++) begin
                        if (req_i.addr == CTL_A[k]) begin
                            rdata_next = ctl_rd[k];
                        end
                        if (k > 0 && req_i.addr == VP_A[k]) begin
                            rdata_next = vp_rd[k];
                        end
                        if (k > 0 && req_i.addr == VS_A[k]) begin
                            rdata_next = vs_rd[k];
                        end
                    end
                end
            endcase
        end

        // registered so the pin never glitches on decode
        irq_next = (batt_flag_reg & batt_unmask_reg) |
                   (therm_flag_reg & therm_unmask_reg) |
                   (|fault_irq);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            batt_unmask_reg  <= 1'b0;
            batt_rsv_reg     <= 1'b0;
            thr_reg          <= '0;
            batt_flag_reg    <= 1'b0;
            batt_prev_reg    <= 1'b0;
            therm_unmask_reg <= 1'b0;
            therm_rsv_reg    <= '0;
            therm_flag_reg   <= 1'b0;
            therm_prev_reg   <= 1'b0;
            rdata_reg        <= `PMU_RST_BYTE;
            irq_reg          <= 1'b0;
        end else begin
            batt_unmask_reg  <= batt_unmask_next;
            batt_rsv_reg     <= batt_rsv_next;
            thr_reg          <= thr_next;
            batt_flag_reg    <= batt_flag_next;
            batt_prev_reg    <= batt_prev_next;
            therm_unmask_reg <= therm_unmask_next;
            therm_rsv_reg    <= therm_rsv_next;
            therm_flag_reg   <= therm_flag_next;
            therm_prev_reg   <= therm_prev_next;
            rdata_reg        <= rdata_next;
            irq_reg          <= irq_next;
        end
    end

    assign rdata_o                    = rdata_reg;
    assign irq_o                      = irq_reg;
    assign battery_detect_threshold_o = thr_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_batt_unmask;
        @(posedge clk_i) disable iff (rst_i)
        batt_flag_reg && batt_unmask_reg && !pmu_rd_hit(req_i, `PMU_A_BATT)
            && !pmu_wr_hit(req_i, `PMU_A_BATT)
            |=> irq_o ##1 irq_o;
    endproperty
    a_batt_unmask: assert property (p_batt_unmask)
        else $error("battery interrupt unmasked but irq low");

    property p_batt_flag;
        @(posedge clk_i) disable iff (rst_i)
        $rose(battery_below_i) ##1 pmu_rd_hit(req_i, `PMU_A_BATT)
            |=> rdata_o[`PMU_B_FLAG];
    endproperty
    a_batt_flag: assert property (p_batt_flag)
        else $error("battery flag not reported after comparator edge");

    property p_batt_live;
        @(posedge clk_i) disable iff (rst_i)
        pmu_rd_hit(req_i, `PMU_A_BATT)
            |=> rdata_o[`PMU_B_LIVE] == $past(battery_below_i);
    endproperty
    a_batt_live: assert property (p_batt_live)
        else $error("live battery bit wrong");

    property p_thr;
        @(posedge clk_i) disable iff (rst_i)
        pmu_wr_hit(req_i, `PMU_A_BATT) ##1 !req_i.wr
            |=> battery_detect_threshold_o == $past(req_i.wdata[3:0], 2);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold not taken from write");

    property p_therm_unmask;
        @(posedge clk_i) disable iff (rst_i)
        therm_flag_reg && therm_unmask_reg && !pmu_rd_hit(req_i, `PMU_A_THERM)
            |=> irq_o;
    endproperty
    a_therm_unmask: assert property (p_therm_unmask)
        else $error("thermal interrupt unmasked but irq low");

    property p_therm_flag;
        @(posedge clk_i) disable iff (rst_i)
        $rose(thermal_alert_i) ##1 pmu_rd_hit(req_i, `PMU_A_THERM)
            |=> rdata_o[`PMU_B_FLAG];
    endproperty
    a_therm_flag: assert property (p_therm_flag)
        else $error("thermal flag not reported after alert edge");

    property p_enable;
        @(posedge clk_i) disable iff (rst_i)
        pmu_wr_hit(req_i, `PMU_A_B1_CTL)
            |=> buck_enable_o[0] == $past(req_i.wdata[`PMU_B_ON]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("buck one enable not taken");

    property p_phase;
        @(posedge clk_i) disable iff (rst_i)
        pmu_wr_hit(req_i, `PMU_A_B2_CTL)
            |=> buck_phase_o[1] == $past(req_i.wdata[`PMU_B_PHASE]);
    endproperty
    a_phase: assert property (p_phase)
        else $error("buck two phase not taken");

    property p_pgood;
        @(posedge clk_i) disable iff (rst_i)
        pmu_rd_hit(req_i, `PMU_A_B2_CTL)
            |=> rdata_o[`PMU_B_OK] == $past(buck_power_good_i[1]);
    endproperty
    a_pgood: assert property (p_pgood)
        else $error("power good readback wrong");

    property p_primary;
        @(posedge clk_i) disable iff (rst_i)
        pmu_wr_hit(req_i, `PMU_A_B2_VP) && !voltage_select_pin_i
            ##1 !voltage_select_pin_i
            |=> buck_vcode_o[0] == $past(req_i.wdata[5:0], 2);
    endproperty
    a_primary: assert property (p_primary)
        else $error("primary code not applied with select low");

    property p_secondary;
        @(posedge clk_i) disable iff (rst_i)
        pmu_wr_hit(req_i, `PMU_A_B3_VS) && voltage_select_pin_i
            ##1 voltage_select_pin_i
            |=> buck_vcode_o[1] == $past(req_i.wdata[5:0], 2);
    endproperty
    a_secondary: assert property (p_secondary)
        else $error("secondary code not applied with select high");

    property p_irq_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(batt_flag_reg && batt_unmask_reg) && !(therm_flag_reg && therm_unmask_reg)
            && buck_fault_i == '0 |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq high without an enabled source");

    property p_rsv_zero;
        @(posedge clk_i) disable iff (rst_i)
        pmu_rd_hit(req_i, `PMU_A_B3_CTL) |=> rdata_o[6:3] == 4'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved control bits not zero");

endmodule : pmu_regbank

// [pmu_regs.svh]
// Function
// - Bit 7 of the battery monitor register unmasks the battery-level interrupt when 1.
// - Read-only bit 6 of the battery monitor register is 1 once a battery-level interrupt was raised.
// - Read-only bit 5 of the battery monitor register is the live below-threshold comparator.
// - Bits 3:0 of the battery monitor register hold the read/write detect threshold.
// - Bit 7 of the thermal register unmasks the thermal interrupt when 1.
// - Read-only bit 6 of the thermal register is 1 once a thermal interrupt was raised.
// - Bit 7 of each regulator control register turns that regulator on (1) or off (0).
// - Bit 2 of each buck control register selects 180 degree (1) or in-phase (0) switching.
// - Bit 1 of each regulator control register enables (1) or blocks (0) its fault interrupt.
// - Read-only bit 0 of each regulator control register is the live power-good flag.
// - Bucks two to four apply the primary six-bit voltage code while the select pin is low.
// - Bucks two to four apply the secondary six-bit voltage code while the select pin is high.
`ifndef PMU_REGS_SVH
`define PMU_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMU_A_BATT      8'h00
`define PMU_A_THERM     8'h01
`define PMU_A_B1_CTL    8'h12
`define PMU_A_B2_VP     8'h20
`define PMU_A_B2_VS     8'h21
`define PMU_A_B2_CTL    8'h22
`define PMU_A_B3_VP     8'h30
`define PMU_A_B3_VS     8'h31
`define PMU_A_B3_CTL    8'h32
`define PMU_A_B4_VP     8'h40
`define PMU_A_B4_VS     8'h41
`define PMU_A_B4_CTL    8'h42

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PMU_B_UNMASK    7
`define PMU_B_FLAG      6
`define PMU_B_LIVE      5
`define PMU_B_BRSV      4
`define PMU_B_ON        7
`define PMU_B_PHASE     2
`define PMU_B_FLTEN     1
`define PMU_B_OK        0
`define PMU_THR_W       4
`define PMU_VCODE_W     6
`define PMU_TRSV_W      6
`define PMU_NBUCK       4
`define PMU_RST_BYTE    8'h00

`endif

// [pmu_system_and_buck_regs_test.sv]
`timescale 1ns/100ps
`include "pmu_regs.svh"

module pmu_system_and_buck_regs_test;
    import pmu_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    pmu_req_t         req;
    logic [7:0]       rdata;
    logic             batt_below = 1'b0;
    logic             therm = 1'b0;
    logic [3:0]       pg = 4'h0;
    logic [3:0]       fault = 4'h0;
    logic             voltage_select_pin = 1'b0;
    logic [3:0]       thr;
    logic [3:0]       en;
    logic [3:0]       ph;
    logic [2:0][5:0]  vcode;
    logic             irq;
    int               err_count = 0;
    int               check_count = 0;
    logic [7:0]       map_a [12] = '{`PMU_A_BATT, `PMU_A_THERM, `PMU_A_B1_CTL, `PMU_A_B2_VP,
                                     `PMU_A_B2_VS, `PMU_A_B2_CTL, `PMU_A_B3_VP, `PMU_A_B3_VS,
                                     `PMU_A_B3_CTL, `PMU_A_B4_VP, `PMU_A_B4_VS, `PMU_A_B4_CTL};
    logic [7:0]       ctl_a [4] = '{`PMU_A_B1_CTL, `PMU_A_B2_CTL, `PMU_A_B3_CTL, `PMU_A_B4_CTL};

    always #25 clk_i = ~clk_i;

    pmu_regbank #(.NBUCK(4)) pmu_regbank_i (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .req_i                      (req),
        .rdata_o                    (rdata),
        .battery_below_i            (batt_below),
        .thermal_alert_i            (therm),
        .buck_power_good_i          (pg),
        .buck_fault_i               (fault),
        .voltage_select_pin_i       (voltage_select_pin),
        .battery_detect_threshold_o (thr),
        .buck_enable_o              (en),
        .buck_phase_o               (ph),
        .buck_vcode_o               (vcode),
        .irq_o                      (irq)
    );

    pmu_host_model pmu_host_model_i (
        .clk_i   (clk_i),
        .req_o   (req),
        .rdata_i (rdata)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        pmu_host_model_i.rd(addr, d);
        check(d, exp, $sformatf("read of %h", addr));
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : cyc

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        foreach (map_a[i]) rchk(map_a[i], 8'h00);
        pmu_host_model_i.wr(8'h13, 8'hFF);
        rchk(8'h13, 8'h00);
    endtask : t_reset

    task automatic t_batt();
        pmu_host_model_i.wr(`PMU_A_BATT, 8'hFF);
        cyc(0);
        check({4'h0, thr}, 8'h0F, "threshold");
        rchk(`PMU_A_BATT, 8'h9F);
        @(posedge clk_i) batt_below <= 1'b1;
        cyc(3);
        check({7'h00, irq}, 8'h01, "battery irq");
        rchk(`PMU_A_BATT, 8'hFF);
        rchk(`PMU_A_BATT, 8'hBF);
        cyc(2);
        check({7'h00, irq}, 8'h00, "battery irq cleared");
        // masked: the flag still sets but must not reach the interrupt
        pmu_host_model_i.wr(`PMU_A_BATT, 8'h0F);
        @(posedge clk_i) batt_below <= 1'b0;
        @(posedge clk_i) batt_below <= 1'b1;
        // read right behind the edge so the flag is seen the cycle after it sets
        rchk(`PMU_A_BATT, 8'h6F);
        check({7'h00, irq}, 8'h00, "battery irq masked");
        @(posedge clk_i) batt_below <= 1'b0;
        rchk(`PMU_A_BATT, 8'h0F);
    endtask : t_batt

    task automatic t_therm();
        pmu_host_model_i.wr(`PMU_A_THERM, 8'hFF);
        rchk(`PMU_A_THERM, 8'hBF);
        @(posedge clk_i) therm <= 1'b1;
        rchk(`PMU_A_THERM, 8'hFF);
        check({7'h00, irq}, 8'h01, "thermal irq");
        rchk(`PMU_A_THERM, 8'hBF);
        cyc(2);
        check({7'h00, irq}, 8'h00, "thermal irq cleared");
        pmu_host_model_i.wr(`PMU_A_THERM, 8'h00);
        @(posedge clk_i) therm <= 1'b0;
    endtask : t_therm

    task automatic t_buck();
        for (int k = 0; k < 4; k++) begin
            pmu_host_model_i.wr(ctl_a[k], 8'hFF);
            cyc(0);
            check({6'h00, en[k], ph[k]}, 8'h03, "enable and phase");
            rchk(ctl_a[k], 8'h86);
            @(posedge clk_i) pg[k] <= 1'b1;
            rchk(ctl_a[k], 8'h87);
            @(posedge clk_i) fault[k] <= 1'b1;
            cyc(2);
            check({7'h00, irq}, 8'h01, "fault irq");
            pmu_host_model_i.wr(ctl_a[k], 8'h80);
            cyc(2);
            check({7'h00, irq}, 8'h00, "fault irq blocked");
            check({7'h00, ph[k]}, 8'h00, "in phase");
            @(posedge clk_i) begin
                fault[k] <= 1'b0;
                pg[k]    <= 1'b0;
            end
            pmu_host_model_i.wr(ctl_a[k], 8'h00);
            cyc(0);
            check({7'h00, en[k]}, 8'h00, "regulator off");
        end
    endtask : t_buck

    task automatic t_vcode();
        logic [7:0] vp;
        for (int k = 1; k < 4; k++) begin
            vp = 8'(8'h10 * (k + 1));
            pmu_host_model_i.wr(vp, 8'hFF);
            pmu_host_model_i.wr(vp + 8'h01, 8'hEA);
            rchk(vp, 8'h3F);
            rchk(vp + 8'h01, 8'h2A);
            cyc(2);
            check({2'h0, vcode[k-1]}, 8'h3F, "primary code");
            @(posedge clk_i) voltage_select_pin <= 1'b1;
            cyc(3);
            check({2'h0, vcode[k-1]}, 8'h2A, "secondary code");
            // rewrite while the pin is high; the new code must follow one edge after the write is taken
            pmu_host_model_i.wr(vp + 8'h01, 8'h15);
            cyc(2);
            check({2'h0, vcode[k-1]}, 8'h15, "secondary rewrite");
            @(posedge clk_i) voltage_select_pin <= 1'b0;
            cyc(3);
            check({2'h0, vcode[k-1]}, 8'h3F, "primary code again");
        end
    endtask : t_vcode

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_batt();
        t_therm();
        t_buck();
        t_vcode();
        complete_run();
    end

    // the whole run needs well under two thousand cycles
    initial begin
        #1000000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

endmodule : pmu_system_and_buck_regs_test
